// File: bench/nmi_control_reset_counter_tb_top.sv
`timescale 1ns/1ps
module nmi_control_reset_counter_tb_top;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic sleep_mode_i = 1'b0;
	logic system_unlocked_i = 1'b0;
	logic deadman_timeout_i, watchdog_timeout_i, clock_fail_i, general_nmi_i;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, nmi_o, wake_o, device_reset_o, irq_o, err;
	int errors = 0;
	int check_count = 0;
	int ctl_m = 0;
	int sts_m = 0;
	int n;
	int src_q[$] = '{0, 1, 2, 3, 1};
	int hpos_q[$] = '{25, 24, 17, 19, 16};
	int wpos_q[$] = '{25, 24, 23, 19, 17, 16};
	always #2.5 clk_sys_i = ~clk_sys_i;
	nmirc_src_model src_u (.clk_sys_i(clk_sys_i), .deadman_o(deadman_timeout_i), .watchdog_o(watchdog_timeout_i),
		.clock_fail_o(clock_fail_i), .general_o(general_nmi_i));
	nmirc_top #(.COUNT_W(16)) dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .deadman_timeout_i(deadman_timeout_i),
		.watchdog_timeout_i(watchdog_timeout_i), .sleep_mode_i(sleep_mode_i), .clock_fail_i(clock_fail_i),
		.general_nmi_i(general_nmi_i), .system_unlocked_i(system_unlocked_i), .nmi_o(nmi_o),
		.wake_o(wake_o), .device_reset_o(device_reset_o), .irq_o(irq_o));
	// ==========================================================
	// Tasks
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (pready_o !== 1'b1 && k < 16);
		if (pready_o !== 1'b1) begin
			errors++;
			give_verdict();
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr_ctl(input logic [31:0] d);
		apb(1'b1, 8'h00, d);
		ctl_m = d & 32'h038b_ffff;
		if ((d & 32'h038b_0000) != 0)
			sts_m |= 1;
		if (d[25:24] != 2'b00)
			sts_m |= 2;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
		if (a == 8'h08)
			sts_m = 0;
	endtask
	task automatic wait_rst(input int exp);
		int k;
		k = 1;
		#1;
		while (device_reset_o !== 1'b1 && k < 40) begin
			@(posedge clk_sys_i);
			#1;
			k++;
		end
		if (device_reset_o !== 1'b1) begin
			k = 0;
			if (exp != 0) begin
				errors++;
				give_verdict();
			end
		end
		chk(k, exp);
	endtask
	task automatic expire(input int cnt);
		wait_rst(cnt + 3);
		ctl_m &= 32'hffff_0000;
		sts_m |= 4;
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(17));
		repeat (20) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd_chk(8'h00, 32'h0000_0000);
		rd_chk(8'h08, 32'h0000_0000);
		rd_chk(8'h0c, 32'h0000_0000);
		$display("reset test done");
		wr_ctl(32'hfcfe_a5c3);
		wait_rst(0);
		rd_chk(8'h00, ctl_m);
		wr_ctl(32'h0000_0000);
		rd_chk(8'h00, 32'h0000_0000);
		$display("field test done");
		foreach (src_q[i]) begin
			n = $urandom_range(0, 6);
			wr_ctl(n);
			sleep_mode_i <= (i == 4);
			src_u.pulse(src_q[i], i);
			ctl_m |= 1 << hpos_q[i];
			sts_m |= (hpos_q[i] >= 24) ? 3 : 1;
			if (hpos_q[i] >= 24)
				expire(n);
			else
				wait_rst(0);
			rd_chk(8'h00, ctl_m);
		end
		sleep_mode_i <= 1'b0;
		rd_chk(8'h08, sts_m);
		$display("source test done");
		foreach (wpos_q[i]) begin
			wr_ctl(32'h1 << wpos_q[i]);
			if (wpos_q[i] >= 24)
				expire(0);
			else
				wait_rst(0);
			rd_chk(8'h00, ctl_m);
		end
		rd_chk(8'h08, sts_m);
		apb(1'b1, 8'h04, 32'h4f00_0000);
		rd_chk(8'h00, ctl_m);
		apb(1'b1, 8'h04, 32'h4e00_0000);
		ctl_m |= 1 << 19;
		rd_chk(8'h00, ctl_m);
		$display("write test done");
		apb(1'b1, 8'h0c, 32'h0000_0006);
		#1 chk(irq_o, 1'b0);
		apb(1'b1, 8'h0c, 32'h0000_0001);
		#1 chk(irq_o, 1'b1);
		rd_chk(8'h0c, 32'h0000_0001);
		rd_chk(8'h08, 32'h0000_0001);
		#1 chk(irq_o, 1'b0);
		$display("interrupt test done");
		apb(1'b1, 8'h10, 32'h0000_0001);
		wait_rst(0);
		@(posedge clk_sys_i);
		system_unlocked_i <= 1'b1;
		apb(1'b1, 8'h10, 32'h0000_0001);
		wait_rst(1);
		rd_chk(8'h10, 32'h0000_0000);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		$display("reset and error test done");
		give_verdict();
	end
endmodule

// File: bench/nmirc_properties.sv
`timescale 1ns/1ps
module nmirc_properties #(
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Sources
	input wire logic deadman_timeout_i,
	input wire logic watchdog_timeout_i,
	input wire logic sleep_mode_i,
	input wire logic clock_fail_i,
	input wire logic general_nmi_i,
	input wire logic system_unlocked_i,
	// Results
	input wire logic nmi_o,
	input wire logic wake_o,
	input wire logic device_reset_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	logic acc;
	logic ev_q;
	assign acc = psel_i & penable_i & pready_o & pwrite_i;
	// ==========================================================
	// Expected nmi cause, one cycle late
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i)
			ev_q <= 1'b0;
		else
			ev_q <= deadman_timeout_i | watchdog_timeout_i | clock_fail_i | general_nmi_i
				| (acc & paddr_i == 8'h00 & |(pwdata_i & 32'h038b_0000))
				| (acc & paddr_i == 8'h04 & pwdata_i[31:24] == 8'h4e);
	end
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence start0_s;
		acc && paddr_i == 8'h00 && pwdata_i[25:24] != 2'b00 && pwdata_i[15:0] == 16'h0000;
	endsequence
	sequence no_wr_s;
		(!(acc && paddr_i == 8'h00)) [*2];
	endsequence
	// ==========================================================
	// Properties
	pready_a: assert property (setup_s |=> pready_o)
		else $error("no answer after setup");
	err_a: assert property (setup_s ##1 (pready_o && paddr_i[1:0] == 2'b00) |-> pslverr_o == (paddr_i > 8'h10))
		else $error("wrong error answer");
	nmi_cause_a: assert property (nmi_o == ev_q)
		else $error("nmi pulse mismatch");
	dm_nmi_a: assert property (deadman_timeout_i |=> nmi_o)
		else $error("no nmi after deadman");
	cf_nmi_a: assert property (clock_fail_i |=> nmi_o)
		else $error("no nmi after clock fail");
	key_nmi_a: assert property (acc && paddr_i == 8'h04 && pwdata_i[31:24] == 8'h4e |=> nmi_o)
		else $error("no nmi after key");
	wake_a: assert property (watchdog_timeout_i && sleep_mode_i |=> wake_o)
		else $error("no wake");
	wake_cause_a: assert property (wake_o |-> $past(watchdog_timeout_i) && $past(sleep_mode_i))
		else $error("stray wake");
	cnt_zero_a: assert property (start0_s ##1 no_wr_s |=> device_reset_o)
		else $error("no reset after countdown");
endmodule

bind nmirc_top nmirc_properties #(.COUNT_W(COUNT_W)) prop_u (
	.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .deadman_timeout_i(deadman_timeout_i),
	.watchdog_timeout_i(watchdog_timeout_i), .sleep_mode_i(sleep_mode_i), .clock_fail_i(clock_fail_i),
	.general_nmi_i(general_nmi_i), .system_unlocked_i(system_unlocked_i), .nmi_o(nmi_o),
	.wake_o(wake_o), .device_reset_o(device_reset_o), .irq_o(irq_o)
);

// File: bench/nmirc_src_model.sv
`timescale 1ns/1ps
module nmirc_src_model (
	// Clock
	input wire logic clk_sys_i,
	// Timeout and failure events
	output logic deadman_o,
	output logic watchdog_o,
	output logic clock_fail_o,
	output logic general_o
);
	logic [3:0] ev = 4'h0;
	assign {general_o, clock_fail_o, watchdog_o, deadman_o} = ev;
	// One-cycle event, prompt or after a delay
	task automatic pulse(input int which, input int gap);
		repeat (gap) @(posedge clk_sys_i);
		@(posedge clk_sys_i);
		ev[which] <= 1'b1;
		@(posedge clk_sys_i);
		ev <= 4'h0;
	endtask
endmodule

// File: hw/nmirc_cnt_if.sv
`timescale 1ns/1ps
interface nmirc_cnt_if #(
	parameter int WIDTH = 16
);
	logic load;
	logic [WIDTH-1:0] load_value;
	logic start;
	logic [WIDTH-1:0] value;
	logic running;
	logic expired;

	modport ctrl (
		output load,
		output load_value,
		output start,
		input value,
		input running,
		input expired
	);

	modport cnt (
		input load,
		input load_value,
		input start,
		output value,
		output running,
		output expired
	);
endinterface

// File: hw/nmirc_countdown.sv
`timescale 1ns/1ps
module nmirc_countdown #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Control
	nmirc_cnt_if.cnt cnt
);

	// ==========================================================
	// Count state
	nmirc_pkg::nmirc_cnt_state_t state;
	logic [WIDTH-1:0] value;
	logic expired;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= nmirc_pkg::NMIRC_CNT_IDLE;
		end else begin
			case (state)
				nmirc_pkg::NMIRC_CNT_IDLE: begin
					if (cnt.start) begin
						state <= nmirc_pkg::NMIRC_CNT_RUN;
					end
				end
				nmirc_pkg::NMIRC_CNT_RUN: begin
					if (value == '0 && !cnt.load) begin
						state <= nmirc_pkg::NMIRC_CNT_IDLE;
					end
				end
				default: begin
					state <= nmirc_pkg::NMIRC_CNT_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Count value, software load wins over decrement
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			value <= '0;
		end else if (cnt.load) begin
			value <= cnt.load_value;
		end else if (state == nmirc_pkg::NMIRC_CNT_RUN && value != '0) begin
			value <= value - WIDTH'(1); // RL11
		end
	end

	// ==========================================================
	// Expiry pulse when the running count sits at zero
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			expired <= 1'b0;
		end else begin
			expired <= state == nmirc_pkg::NMIRC_CNT_RUN && value == '0 && !cnt.load; // RL11
		end
	end

	assign cnt.value = value;
	assign cnt.running = state == nmirc_pkg::NMIRC_CNT_RUN;
	assign cnt.expired = expired;

endmodule

// File: hw/nmirc_pkg.sv
package nmirc_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] NMI_CONTROL_OFS = 8'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_REGISTER_OFS = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [7:0] SYS_RESET_CTRL_OFS = 8'h10;

	// ==========================================================
	// Field positions of nmi_control
	localparam int DEADMAN_TIMEOUT_FLAG_POS = 25;
	localparam int WATCHDOG_TIMEOUT_FLAG_POS = 24;
	localparam int SOFTWARE_NMI_TRIGGER_POS = 23;
	localparam int GENERAL_NMI_FLAG_POS = 19;
	localparam int CLOCK_FAIL_FLAG_POS = 17;
	localparam int SLEEP_WATCHDOG_FLAG_POS = 16;
	localparam int NMI_RESET_COUNT_LSB = 0;
	localparam int NMI_RESET_COUNT_W = 16;

	// ==========================================================
	// Key field of interrupt_control_register
	localparam int NMI_KEY_FIELD_LSB = 24;
	localparam int NMI_KEY_FIELD_W = 8;
	localparam logic [7:0] NMI_KEY_VALUE = 8'h4e;

	// ==========================================================
	// Software reset control and interrupt status layout
	localparam int SOFTWARE_RESET_BIT_POS = 0;
	localparam int IRQ_NMI_POS = 0;
	localparam int IRQ_COUNT_START_POS = 1;
	localparam int IRQ_COUNT_EXPIRE_POS = 2;
	localparam int IRQ_W = 3;

	// ==========================================================
	// Reset values
	localparam logic [31:0] NMI_CONTROL_RST = 32'h0000_0000;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// ==========================================================
	// Countdown states
	typedef enum logic [1:0] {
		NMIRC_CNT_IDLE = 2'b01,
		NMIRC_CNT_RUN = 2'b10
	} nmirc_cnt_state_t;

endpackage

// File: hw/nmirc_top.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
// How it works
// RL1 - Deadman timeout sets bit 25 flag and raises an NMI.
// RL2 - Writing one to bit 25 raises deadman NMI and starts countdown.
// RL3 - Awake watchdog timeout sets bit 24; writing one does the same.
// RL4 - Writing one to bit 23 raises an NMI; zero raises none.
// RL5 - General NMI event sets bit 19; writing one raises a user NMI.
// RL6 - Writing 0x4E to key field bits 31:24 sets the general flag.
// RL7 - Clock monitor failure sets bit 17 and raises an NMI.
// RL8 - Writing one to bit 17 raises an NMI, no oscillator switch.
// RL9 - Watchdog timeout in Sleep sets bit 16 and wakes the device.
// RL10 - Writing one to bit 16 raises a watchdog NMI.
// RL11 - 16-bit writable count decrements after trigger, resets device at zero.
// RL12 - Only awake watchdog or deadman NMIs start the countdown.
// RL13 - Unimplemented bits read zero and ignore writes.
// RL14 - Software reset bit writes need system unlock, else rejected.
// RL15 - All implemented fields clear to zero at reset.
// RL16 - Source flags stay set until software writes zero.
module nmirc_top #(
	parameter int COUNT_W = nmirc_pkg::NMI_RESET_COUNT_W
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// NMI sources
	input wire logic deadman_timeout_i,
	input wire logic watchdog_timeout_i,
	input wire logic sleep_mode_i,
	input wire logic clock_fail_i,
	input wire logic general_nmi_i,
	input wire logic system_unlocked_i,
	// NMI and reset outputs
	output logic nmi_o,
	output logic wake_o,
	output logic device_reset_o,
	output logic irq_o
);

	// ==========================================================
	// Helpers
	function automatic logic wr_bit(input logic wr, input logic [31:0] data, input int pos);
		wr_bit = wr & data[pos];
	endfunction

	function automatic logic next_flag(input logic cur, input logic evt, input logic wr,
		input logic [31:0] data, input int pos);
		if (evt) begin
			next_flag = 1'b1;
		end else if (wr) begin
			next_flag = data[pos];
		end else begin
			next_flag = cur;
		end
	endfunction

	// ==========================================================
	// APB access decode
	logic setup;
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic mapped;
	logic wr_ctrl;
	logic wr_key;
	logic wr_mask;
	logic wr_sysrst;
	logic rd_status;

	assign setup = psel_i & ~penable_i;
	assign access_done = psel_i & penable_i & pready_o;
	assign wr_done = access_done & pwrite_i;
	assign rd_done = access_done & ~pwrite_i;
	assign mapped = paddr_i == nmirc_pkg::NMI_CONTROL_OFS || paddr_i == nmirc_pkg::INTERRUPT_CONTROL_REGISTER_OFS
		|| paddr_i == nmirc_pkg::IRQ_STATUS_OFS || paddr_i == nmirc_pkg::IRQ_MASK_OFS
		|| paddr_i == nmirc_pkg::SYS_RESET_CTRL_OFS;
	assign wr_ctrl = wr_done & (paddr_i == nmirc_pkg::NMI_CONTROL_OFS);
	assign wr_key = wr_done & (paddr_i == nmirc_pkg::INTERRUPT_CONTROL_REGISTER_OFS);
	assign wr_mask = wr_done & (paddr_i == nmirc_pkg::IRQ_MASK_OFS);
	assign wr_sysrst = wr_done & (paddr_i == nmirc_pkg::SYS_RESET_CTRL_OFS);
	assign rd_status = rd_done & (paddr_i == nmirc_pkg::IRQ_STATUS_OFS);

	// ==========================================================
	// NMI source events
	logic key_ok;
	logic deadman_evt;
	logic watchdog_evt;
	logic software_nmi_trigger_evt;
	logic general_evt;
	logic clock_fail_evt;
	logic sleep_wdt_evt;
	logic any_evt;

	assign key_ok = wr_key && pwdata_i[nmirc_pkg::NMI_KEY_FIELD_LSB +: nmirc_pkg::NMI_KEY_FIELD_W]
		== nmirc_pkg::NMI_KEY_VALUE; // RL6
	assign deadman_evt = deadman_timeout_i
		| wr_bit(wr_ctrl, pwdata_i, nmirc_pkg::DEADMAN_TIMEOUT_FLAG_POS); // RL1 RL2
	assign watchdog_evt = (watchdog_timeout_i & ~sleep_mode_i)
		| wr_bit(wr_ctrl, pwdata_i, nmirc_pkg::WATCHDOG_TIMEOUT_FLAG_POS); // RL3
	assign software_nmi_trigger_evt = wr_bit(wr_ctrl, pwdata_i, nmirc_pkg::SOFTWARE_NMI_TRIGGER_POS); // RL4
	assign general_evt = general_nmi_i | key_ok
		| wr_bit(wr_ctrl, pwdata_i, nmirc_pkg::GENERAL_NMI_FLAG_POS); // RL5
	assign clock_fail_evt = clock_fail_i
		| wr_bit(wr_ctrl, pwdata_i, nmirc_pkg::CLOCK_FAIL_FLAG_POS); // RL7 RL8
	assign sleep_wdt_evt = (watchdog_timeout_i & sleep_mode_i)
		| wr_bit(wr_ctrl, pwdata_i, nmirc_pkg::SLEEP_WATCHDOG_FLAG_POS); // RL9 RL10
	assign any_evt = deadman_evt | watchdog_evt | software_nmi_trigger_evt | general_evt | clock_fail_evt | sleep_wdt_evt;

	// ==========================================================
	// Source flags
	logic deadman_timeout_flag;
	logic watchdog_timeout_flag;
	logic software_nmi_trigger;
	logic general_nmi_flag;
	logic clock_fail_flag;
	logic sleep_watchdog_flag;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			deadman_timeout_flag <= 1'b0; // RL15
			watchdog_timeout_flag <= 1'b0;
			software_nmi_trigger <= 1'b0;
			general_nmi_flag <= 1'b0;
			clock_fail_flag <= 1'b0;
			sleep_watchdog_flag <= 1'b0;
		end else begin
			deadman_timeout_flag <= next_flag(deadman_timeout_flag, deadman_evt, wr_ctrl, pwdata_i,
				nmirc_pkg::DEADMAN_TIMEOUT_FLAG_POS); // RL16
			watchdog_timeout_flag <= next_flag(watchdog_timeout_flag, watchdog_evt, wr_ctrl, pwdata_i,
				nmirc_pkg::WATCHDOG_TIMEOUT_FLAG_POS); // RL16
			software_nmi_trigger <= next_flag(software_nmi_trigger, 1'b0, wr_ctrl, pwdata_i,
				nmirc_pkg::SOFTWARE_NMI_TRIGGER_POS);
			general_nmi_flag <= next_flag(general_nmi_flag, general_evt, wr_ctrl, pwdata_i,
				nmirc_pkg::GENERAL_NMI_FLAG_POS); // RL16
			clock_fail_flag <= next_flag(clock_fail_flag, clock_fail_evt, wr_ctrl, pwdata_i,
				nmirc_pkg::CLOCK_FAIL_FLAG_POS); // RL16
			sleep_watchdog_flag <= next_flag(sleep_watchdog_flag, sleep_wdt_evt, wr_ctrl, pwdata_i,
				nmirc_pkg::SLEEP_WATCHDOG_FLAG_POS); // RL16
		end
	end

	// ==========================================================
	// NMI and wake pulses
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nmi_o <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			nmi_o <= any_evt; // RL4
			wake_o <= watchdog_timeout_i & sleep_mode_i; // RL9
		end
	end

	// ==========================================================
	// Reset countdown
	nmirc_cnt_if #(.WIDTH(COUNT_W)) cnt_bus ();

	assign cnt_bus.load = wr_ctrl;
	assign cnt_bus.load_value = pwdata_i[nmirc_pkg::NMI_RESET_COUNT_LSB +: COUNT_W]; // RL11
	assign cnt_bus.start = deadman_evt | watchdog_evt; // RL12

	nmirc_countdown #(
		.WIDTH(COUNT_W)
	) u_countdown (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.cnt(cnt_bus)
	);

	// ==========================================================
	// Device reset from countdown or unlocked software reset
	logic software_reset_bit_ok;

	assign software_reset_bit_ok = wr_bit(wr_sysrst, pwdata_i, nmirc_pkg::SOFTWARE_RESET_BIT_POS) & system_unlocked_i; // RL14

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			device_reset_o <= 1'b0;
		end else begin
			device_reset_o <= cnt_bus.expired | software_reset_bit_ok; // RL11
		end
	end

	// ==========================================================
	// Interrupt status and mask
	logic [nmirc_pkg::IRQ_W-1:0] irq_status;
	logic [nmirc_pkg::IRQ_W-1:0] irq_mask;
	logic [nmirc_pkg::IRQ_W-1:0] irq_set;
	logic [nmirc_pkg::IRQ_W-1:0] irq_clr;
	logic [nmirc_pkg::IRQ_W-1:0] irq_read;

	always_comb begin
		irq_set = '0;
		irq_set[nmirc_pkg::IRQ_NMI_POS] = any_evt;
		irq_set[nmirc_pkg::IRQ_COUNT_START_POS] = cnt_bus.start;
		irq_set[nmirc_pkg::IRQ_COUNT_EXPIRE_POS] = cnt_bus.expired;
	end

	assign irq_clr = rd_status ? irq_read : '0;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_status <= nmirc_pkg::IRQ_RST;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_mask <= nmirc_pkg::IRQ_RST;
		end else if (wr_mask) begin
			irq_mask <= pwdata_i[nmirc_pkg::IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// ==========================================================
	// Read mux
	logic [31:0] rd_word;

	always_comb begin
		rd_word = nmirc_pkg::NMI_CONTROL_RST; // RL13
		case (paddr_i)
			nmirc_pkg::NMI_CONTROL_OFS: begin
				rd_word[nmirc_pkg::DEADMAN_TIMEOUT_FLAG_POS] = deadman_timeout_flag;
				rd_word[nmirc_pkg::WATCHDOG_TIMEOUT_FLAG_POS] = watchdog_timeout_flag;
				rd_word[nmirc_pkg::SOFTWARE_NMI_TRIGGER_POS] = software_nmi_trigger;
				rd_word[nmirc_pkg::GENERAL_NMI_FLAG_POS] = general_nmi_flag;
				rd_word[nmirc_pkg::CLOCK_FAIL_FLAG_POS] = clock_fail_flag;
				rd_word[nmirc_pkg::SLEEP_WATCHDOG_FLAG_POS] = sleep_watchdog_flag;
				rd_word[nmirc_pkg::NMI_RESET_COUNT_LSB +: COUNT_W] = cnt_bus.value;
			end
			nmirc_pkg::IRQ_STATUS_OFS: begin
				rd_word[nmirc_pkg::IRQ_W-1:0] = irq_status;
			end
			nmirc_pkg::IRQ_MASK_OFS: begin
				rd_word[nmirc_pkg::IRQ_W-1:0] = irq_mask;
			end
			default: begin
				rd_word = nmirc_pkg::NMI_CONTROL_RST;
			end
		endcase
	end

	// ==========================================================
	// Bus answer: no wait state, data captured at end of setup
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= setup;
			pslverr_o <= setup & ~mapped;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_o <= '0;
			irq_read <= '0;
		end else if (setup) begin
			prdata_o <= pwrite_i ? 32'h0000_0000 : rd_word;
			irq_read <= rd_word[nmirc_pkg::IRQ_W-1:0];
		end
	end

endmodule
